// >>> hw/synth_serial_map.svh
// Bit positions, latch addresses, encodings and reset values of the serial control block.
// Assumes it is included by its bare name from the design file and the bench.
`ifndef SYNTH_SERIAL_MAP_SVH
`define SYNTH_SERIAL_MAP_SVH
`define WORD_BITS          22
`define ADDR_REFERENCE     2'h0
`define ADDR_FEEDBACK      2'h1
`define ADDR_TIMEOUT       2'h2
`define REF_DIV_MSB        16
`define REF_DIV_LSB        2
`define BIT_POLARITY       17
`define BIT_PUMP_BOOST     18
`define BIT_PUMP_FLOAT     19
`define BIT_MON0           20
`define BIT_MON1           21
`define BIT_POWER_DOWN     21
`define BIT_PRESCALER      20
`define MAIN_MSB           19
`define MAIN_LSB           7
`define SWALLOW_MSB        6
`define SWALLOW_LSB        2
`define BIT_MON2           14
`define TIMEOUT_MSB        13
`define TIMEOUT_LSB        2
`define TO_OFF             12'h000
`define TO_MANUAL          12'h001
`define TO_FORCE_LOW       12'h002
`define TO_FORCE_HIGH      12'h003
`define WORD_RESET         22'h000000
`endif

// >>> hw/synth_serial_pkg.sv
// Types shared by the serial control block.
// Assumes synth_serial_map.svh is on the include path.
package synth_serial_pkg;
  typedef enum logic [2:0] {
    mon_float      = 3'h0,
    mon_lock_pp    = 3'h1,
    mon_lock_od    = 3'h2,
    mon_reset_div  = 3'h3,
    mon_dig_lock   = 3'h4,
    mon_ref_out    = 3'h5,
    mon_fb_out     = 3'h6,
    mon_reserved   = 3'h7
  } monitor_mode_t;
  typedef enum logic [1:0] {
    pwr_normal     = 2'h0,
    pwr_wait_pulse = 2'h1,
    pwr_down       = 2'h2
  } power_state_t;
endpackage

// >>> hw/synth_serial_control_regs.sv
// Serial programming shift register, three control latches and the fast-acquire timer.
// Assumes serial pins arrive asynchronously to mclk; analog status comes in on mclk.
//
// Overview of operation
// - 22-bit shifter: 20 data, 2 address bits.
// - Shift MSB first on serial clock rise.
// - Latch strobe rise copies word by address.
// - Reference latch field positions decoded.
// - Reference divide 2 to 32767; host obeys.
// - Polarity bit sets pump direction.
// - Boost selects 1 or 4 mA immediately.
// - Float bit tri-states pump immediately.
// - Three select bits route monitor output.
// - Feedback latch field positions decoded.
// - Power-down and float choose power mode.
// - Prescaler bit selects dual-modulus ratio.
// - Main count 3 to 8191; host obeys.
// - Swallow count accepts 0 to 31.
// - Timeout latch fields; upper bits zero.
// - Timeout 0: switch floats, boost rules.
// - Timeout 1: switch low, forced 4 mA.
// - Timeout 2 low, 3 high, boost rules.
// - Timeout 4..4095 timed 4 mA, then 1 mA.
// - Count down per reference cycle; release.
// - While active: switch low, 4 mA.
// - Synchronous down waits pulse end.
// - Programming works during power-down.
`timescale 1ns/1ps
`include "synth_serial_map.svh"
module synth_serial_control_regs #(
  parameter int REF_W  = 15,
  parameter int MAIN_W = 13,
  parameter int SWAL_W = 5,
  parameter int TO_W   = 12
) (
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire logic              serial_clock,
  input  wire logic              serial_data,
  input  wire logic              latch_strobe,
  input  wire logic              reference_tick,
  input  wire logic              pump_pulse_active,
  input  wire logic              analog_lock,
  input  wire logic              digital_lock,
  input  wire logic              reference_div_out,
  input  wire logic              feedback_div_out,
  output logic [REF_W-1:0]       reference_divide_word,
  output logic [MAIN_W-1:0]      main_feedback_count,
  output logic [SWAL_W-1:0]      swallow_count,
  output logic                   prescaler_select,
  output logic                   detector_polarity,
  output logic                   pump_high_current,
  output logic                   pump_output_oe,
  output logic                   dividers_reset,
  output logic                   powered_down,
  output logic                   monitor_output,
  output logic                   monitor_output_oe,
  output logic                   acquire_switch_output,
  output logic                   acquire_switch_output_oe
);

  logic [2:0] sclk_sync;
  logic [2:0] strobe_sync;
  logic [1:0] data_sync;
  logic [2:0] tick_sync;
  logic [`WORD_BITS-1:0] shift_word;
  logic [`WORD_BITS-1:0] reference_divider_word;
  logic [`WORD_BITS-1:0] feedback_divider_word;
  logic [`WORD_BITS-1:0] acquire_timeout_word;
  logic [TO_W-1:0]       acquire_count;
  logic                  timed_active;
  logic                  load_timeout;
  logic                  sclk_rise;
  logic                  strobe_rise;
  logic                  tick_rise;
  logic                  pulse_seen;
  logic                  pump_boost;
  logic                  pump_float;
  logic                  power_down_bit;
  logic [TO_W-1:0]       acquire_timeout_value;
  synth_serial_pkg::monitor_mode_t monitor_mode;
  synth_serial_pkg::power_state_t  power_state;
  synth_serial_pkg::power_state_t  next_power_state;

  // Stage 0 of each chain feeds only stage 1; edges are taken between stages 1 and 2.
  pin_sync #(.STAGES(3)) sclk_sync_i (
    .mclk  (mclk),
    .rst_n (rst_n),
    .pin   (serial_clock),
    .taps  (sclk_sync)
  );
  pin_sync #(.STAGES(3)) strobe_sync_i (
    .mclk  (mclk),
    .rst_n (rst_n),
    .pin   (latch_strobe),
    .taps  (strobe_sync)
  );
  pin_sync #(.STAGES(2)) data_sync_i (
    .mclk  (mclk),
    .rst_n (rst_n),
    .pin   (serial_data),
    .taps  (data_sync)
  );
  pin_sync #(.STAGES(3)) tick_sync_i (
    .mclk  (mclk),
    .rst_n (rst_n),
    .pin   (reference_tick),
    .taps  (tick_sync)
  );

  assign sclk_rise   = sclk_sync[1] & ~sclk_sync[2];
  assign strobe_rise = strobe_sync[1] & ~strobe_sync[2];
  assign tick_rise   = tick_sync[1] & ~tick_sync[2];

  // The shifter ignores power state, so the latches can be rewritten while powered down.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      shift_word <= `WORD_RESET;
    end else if (sclk_rise) begin
      shift_word <= {shift_word[`WORD_BITS-2:0], data_sync[1]};
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      reference_divider_word <= `WORD_RESET;
      feedback_divider_word  <= `WORD_RESET;
      acquire_timeout_word   <= `WORD_RESET;
    end else if (strobe_rise) begin
      case (shift_word[1:0])
        `ADDR_REFERENCE: begin
          reference_divider_word <= shift_word;
        end
        `ADDR_FEEDBACK: begin
          feedback_divider_word <= shift_word;
        end
        `ADDR_TIMEOUT: begin
          acquire_timeout_word <= shift_word;
        end
        default: begin
          reference_divider_word <= reference_divider_word;
        end
      endcase
    end
  end

  assign load_timeout = strobe_rise && (shift_word[1:0] == `ADDR_TIMEOUT);

  assign pump_boost     = reference_divider_word[`BIT_PUMP_BOOST];
  assign pump_float     = reference_divider_word[`BIT_PUMP_FLOAT];
  assign power_down_bit = feedback_divider_word[`BIT_POWER_DOWN];
  // Bits 21..15 of the timeout word are not decoded; the host writes them as zero.
  assign acquire_timeout_value = acquire_timeout_word[`TIMEOUT_MSB:`TIMEOUT_LSB];
  assign monitor_mode = synth_serial_pkg::monitor_mode_t'({acquire_timeout_word[`BIT_MON2],
                        reference_divider_word[`BIT_MON1],
                        reference_divider_word[`BIT_MON0]});

  // Divider words are passed on as stored; legal ranges are the host's duty.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      reference_divide_word <= '0;
      detector_polarity     <= 1'b0;
      main_feedback_count   <= '0;
      swallow_count         <= '0;
      prescaler_select      <= 1'b0;
    end else begin
      reference_divide_word <= reference_divider_word[`REF_DIV_MSB:`REF_DIV_LSB];
      detector_polarity     <= reference_divider_word[`BIT_POLARITY];
      main_feedback_count   <= feedback_divider_word[`MAIN_MSB:`MAIN_LSB];
      swallow_count         <= feedback_divider_word[`SWALLOW_MSB:`SWALLOW_LSB];
      prescaler_select      <= feedback_divider_word[`BIT_PRESCALER];
    end
  end

  // A new timeout word restarts the timer; values 4 and up count reference cycles.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      acquire_count <= '0;
      timed_active  <= 1'b0;
    end else if (load_timeout) begin
      acquire_count <= shift_word[`TIMEOUT_MSB:`TIMEOUT_LSB];
      timed_active  <= (shift_word[`TIMEOUT_MSB:`TIMEOUT_LSB] > `TO_FORCE_HIGH);
    end else if (timed_active && tick_rise) begin
      acquire_count <= acquire_count - 1'b1;
      if (acquire_count == {{(TO_W-1){1'b0}}, 1'b1}) begin
        timed_active <= 1'b0;
      end
    end
  end

  // Boost changes reach the output the next cycle, with no wait on a pump cycle.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pump_high_current <= 1'b0;
    end else if (timed_active) begin
      pump_high_current <= 1'b1;
    end else begin
      case (acquire_timeout_value)
        `TO_OFF: begin
          pump_high_current <= pump_boost;
        end
        `TO_MANUAL: begin
          pump_high_current <= 1'b1;
        end
        `TO_FORCE_LOW, `TO_FORCE_HIGH: begin
          pump_high_current <= pump_boost;
        end
        default: begin
          // An expired timer stays at 1 mA even with boost set, until the host rewrites it.
          pump_high_current <= 1'b0;
        end
      endcase
    end
  end

  // Values 1 to 3 hold the switch for good; an expired timer lets it float.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      acquire_switch_output    <= 1'b0;
      acquire_switch_output_oe <= 1'b0;
    end else if (timed_active) begin
      acquire_switch_output    <= 1'b0;
      acquire_switch_output_oe <= 1'b1;
    end else begin
      case (acquire_timeout_value)
        `TO_MANUAL, `TO_FORCE_LOW: begin
          acquire_switch_output    <= 1'b0;
          acquire_switch_output_oe <= 1'b1;
        end
        `TO_FORCE_HIGH: begin
          acquire_switch_output    <= 1'b1;
          acquire_switch_output_oe <= 1'b1;
        end
        default: begin
          acquire_switch_output    <= 1'b0;
          acquire_switch_output_oe <= 1'b0;
        end
      endcase
    end
  end

  // A pulse counts as finished only on its falling edge, so an idle pump keeps waiting.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pulse_seen <= 1'b0;
    end else begin
      pulse_seen <= pump_pulse_active;
    end
  end

  // Synchronous power-down waits for the running pump pulse; the host clears the power-down bit to wake.
  always_comb begin
    next_power_state = power_state;
    case (power_state)
      synth_serial_pkg::pwr_normal: begin
        if (power_down_bit && pump_float) begin
          next_power_state = synth_serial_pkg::pwr_down;
        end else if (power_down_bit) begin
          next_power_state = synth_serial_pkg::pwr_wait_pulse;
        end
      end
      synth_serial_pkg::pwr_wait_pulse: begin
        if (!power_down_bit) begin
          next_power_state = synth_serial_pkg::pwr_normal;
        end else if (pump_float || (pulse_seen && !pump_pulse_active)) begin
          next_power_state = synth_serial_pkg::pwr_down;
        end
      end
      synth_serial_pkg::pwr_down: begin
        if (!power_down_bit) begin
          next_power_state = synth_serial_pkg::pwr_normal;
        end
      end
      default: begin
        next_power_state = synth_serial_pkg::pwr_normal;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      power_state <= synth_serial_pkg::pwr_normal;
    end else begin
      power_state <= next_power_state;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      powered_down   <= 1'b0;
      pump_output_oe <= 1'b0;
      dividers_reset <= 1'b0;
    end else begin
      powered_down   <= (next_power_state == synth_serial_pkg::pwr_down);
      dividers_reset <= (monitor_mode == synth_serial_pkg::mon_reset_div) ||
                        (next_power_state == synth_serial_pkg::pwr_down);
      pump_output_oe <= !pump_float && (monitor_mode != synth_serial_pkg::mon_reset_div) &&
                        (next_power_state != synth_serial_pkg::pwr_down);
    end
  end

  // Lock indication reads low during power-down.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      monitor_output    <= 1'b0;
      monitor_output_oe <= 1'b0;
    end else begin
      case (monitor_mode)
        synth_serial_pkg::mon_lock_pp: begin
          monitor_output    <= analog_lock && !powered_down;
          monitor_output_oe <= 1'b1;
        end
        synth_serial_pkg::mon_lock_od: begin
          monitor_output    <= 1'b0;
          monitor_output_oe <= !analog_lock || powered_down;
        end
        synth_serial_pkg::mon_dig_lock: begin
          monitor_output    <= digital_lock && !powered_down;
          monitor_output_oe <= 1'b1;
        end
        synth_serial_pkg::mon_ref_out: begin
          monitor_output    <= reference_div_out;
          monitor_output_oe <= 1'b1;
        end
        synth_serial_pkg::mon_fb_out: begin
          monitor_output    <= feedback_div_out;
          monitor_output_oe <= 1'b1;
        end
        default: begin
          monitor_output    <= 1'b0;
          monitor_output_oe <= 1'b0;
        end
      endcase
    end
  end

endmodule

// Chain of flip-flops that brings one pin into the mclk domain.
module pin_sync #(
  parameter int STAGES = 3
) (
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire logic              pin,
  output logic [STAGES-1:0]      taps
);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      taps <= '0;
    end else begin
      taps <= {taps[STAGES-2:0], pin};
    end
  end

endmodule

// >>> sim/synth_serial_check_assertions.sv
// Checker of the serial control block, bound to its top-level ports.
// Assumes strobe and tick pins stay high six mclk cycles or more per pulse.
`timescale 1ns/1ps
module synth_serial_check #(
  parameter int REF_W  = 15,
  parameter int MAIN_W = 13,
  parameter int SWAL_W = 5
) (
  input wire logic              mclk,
  input wire logic              rst_n,
  input wire logic              latch_strobe,
  input wire logic              reference_tick,
  input wire logic              pump_pulse_active,
  input wire logic [REF_W-1:0]  reference_divide_word,
  input wire logic [MAIN_W-1:0] main_feedback_count,
  input wire logic [SWAL_W-1:0] swallow_count,
  input wire logic              pump_high_current,
  input wire logic              pump_output_oe,
  input wire logic              dividers_reset,
  input wire logic              powered_down,
  input wire logic              acquire_switch_output_oe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Pins pass a synchronizer, so a cause is looked for three cycles back.
  reset_clear_a: assert property ($rose(rst_n) |-> !acquire_switch_output_oe)
    else $error("switch driven after reset");
  fields_strobe_a: assert property (
    $changed({reference_divide_word, main_feedback_count, swallow_count})
    |-> $past(latch_strobe, 3)) else $error("field changed without strobe");
  boost_cause_a: assert property ($changed(pump_high_current) |->
    $past(latch_strobe, 3) || $past(reference_tick, 3) || $changed(powered_down))
    else $error("pump current changed without cause");
  expiry_tick_a: assert property ($fell(acquire_switch_output_oe) |->
    $past(latch_strobe, 3) || $past(reference_tick, 3)) else $error("switch released early");
  sync_wait_a: assert property ($rose(powered_down) && $past(pump_output_oe) |->
    !$past(pump_pulse_active) && $past(pump_pulse_active, 2)) else $error("down mid pulse");
  down_float_a: assert property (powered_down && $past(powered_down, 2)
    |-> !pump_output_oe) else $error("pump driven in power-down");
  down_reset_a: assert property (powered_down && $past(powered_down, 2)
    |-> dividers_reset) else $error("dividers run in power-down");
  wake_write_a: assert property ($fell(powered_down) |-> $past(latch_strobe, 3))
    else $error("woke without a write");
endmodule
bind synth_serial_control_regs synth_serial_check #(.REF_W(REF_W), .MAIN_W(MAIN_W),
  .SWAL_W(SWAL_W)) synth_serial_check_i (.mclk, .rst_n, .latch_strobe, .reference_tick,
  .pump_pulse_active, .reference_divide_word, .main_feedback_count, .swallow_count,
  .pump_high_current, .pump_output_oe, .dividers_reset, .powered_down, .acquire_switch_output_oe);

// >>> sim/host_serial_model.sv
// Host side of the three-wire bus: shifts one word per request, then strobes it in.
// Assumes go rises on a falling mclk edge and is held until busy rises.
`timescale 1ns/1ps
module host_serial_model (
  input wire logic        mclk,
  input wire logic        go,
  input wire logic [21:0] word,
  output logic            serial_clock,
  output logic            serial_data,
  output logic            latch_strobe,
  output logic            busy
);
  initial begin
    {serial_clock, serial_data, latch_strobe, busy} = 4'h0;
    forever begin
      @(posedge mclk);
      if (go) begin
        @(negedge mclk);
        busy = 1'b1;
        // The clock stands low between frames; each half period is four mclk cycles.
        for (int i = 21; i >= 0; i--) begin
          serial_data = word[i];
          repeat (4) @(negedge mclk);
          serial_clock = 1'b1;
          repeat (4) @(negedge mclk);
          serial_clock = 1'b0;
        end
        // Flipped so that a held last bit cannot pass for a fresh one.
        serial_data = ~serial_data;
        repeat (2) @(negedge mclk);
        latch_strobe = 1'b1;
        repeat (8) @(negedge mclk);
        latch_strobe = 1'b0;
        repeat (4) @(negedge mclk);
        busy = 1'b0;
      end
    end
  end
endmodule

// >>> sim/synth_serial_control_regs_test.sv
// Bench for the serial control block: a host model programs it and the pins are compared.
// Assumes the map header, design, checker and host model are compiled first.
`timescale 1ns/1ps
`include "synth_serial_map.svh"
module synth_serial_control_regs_test;
  logic        mclk = 1'b0, rst_n = 1'b0, go = 1'b0, reference_tick = 1'b0;
  logic        pump_pulse_active = 1'b0, analog_lock = 1'b0, digital_lock = 1'b0;
  logic        reference_div_out = 1'b0, feedback_div_out = 1'b0;
  logic [21:0] word = 22'h000000;
  logic [14:0] reference_divide_word;
  logic [12:0] main_feedback_count;
  logic [4:0]  swallow_count;
  logic        busy, serial_clock, serial_data, latch_strobe, prescaler_select;
  logic        detector_polarity, pump_high_current, pump_output_oe, dividers_reset;
  logic        powered_down, monitor_output, monitor_output_oe, acquire_switch_output;
  logic        acquire_switch_output_oe;
  int          failures = 0, checks_done = 0;
  always #50 mclk = ~mclk;
  synth_serial_control_regs synth_serial_control_regs_i (.mclk, .rst_n, .serial_clock,
    .serial_data, .latch_strobe, .reference_tick, .pump_pulse_active, .analog_lock,
    .digital_lock, .reference_div_out, .feedback_div_out, .reference_divide_word,
    .main_feedback_count, .swallow_count, .prescaler_select, .detector_polarity,
    .pump_high_current, .pump_output_oe, .dividers_reset, .powered_down, .monitor_output,
    .monitor_output_oe, .acquire_switch_output, .acquire_switch_output_oe);
  host_serial_model host_serial_model_i (.mclk, .go, .word, .serial_clock, .serial_data,
    .latch_strobe, .busy);
  function automatic logic [21:0] rw(input logic [1:0] mon, input logic fl, bo, pol,
                                     input logic [14:0] d);
    return {mon, fl, bo, pol, d, `ADDR_REFERENCE};
  endfunction
  function automatic logic [21:0] fw(input logic pd, ps, input logic [12:0] b,
                                     input logic [4:0] a);
    return {pd, ps, b, a, `ADDR_FEEDBACK};
  endfunction
  function automatic logic [21:0] tw(input logic m2, input logic [11:0] t);
    return {7'h00, m2, t, `ADDR_TIMEOUT};
  endfunction
  function automatic logic [1:0] mon_exp(input logic [2:0] m);
    case (m)
      3'h1: return {1'b1, analog_lock};
      3'h2: return {!analog_lock, 1'b0};
      3'h4: return {1'b1, digital_lock};
      3'h5: return {1'b1, reference_div_out};
      3'h6: return {1'b1, feedback_div_out};
      default: return 2'h0;
    endcase
  endfunction
  task automatic end_sim();
    $display("failures %0d checks_done %0d", failures, checks_done);
    if (failures == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic send(input logic [21:0] w);
    int n = 0;
    @(negedge mclk);
    word = w;
    go = 1'b1;
    while ((go || busy !== 1'b0) && n < 400) begin
      @(negedge mclk);
      n++;
      if (busy === 1'b1) go = 1'b0;
    end
    if (n >= 400) begin
      failures++;
      $display("BAD %0t host model hung", $time);
      end_sim();
    end
    repeat (8) @(negedge mclk);
  endtask
  task automatic tick(input int k);
    repeat (k) begin
      reference_tick = 1'b1;
      repeat (6) @(negedge mclk);
      reference_tick = 1'b0;
      repeat (6) @(negedge mclk);
    end
  endtask
  task automatic chk_sw(input int t, input logic bo);
    check(acquire_switch_output_oe, t != 0);
    if (t != 0) check(acquire_switch_output, t == 3);
    check(pump_high_current, t == 1 || t > 3 || bo);
  endtask
  initial begin
    logic [14:0] d;
    logic [12:0] b;
    logic [4:0]  a;
    logic [1:0]  e;
    logic        p, bo;
    int          t;
    d = 15'($urandom(32'h3690));
    repeat (20) @(negedge mclk);
    rst_n = 1'b1;
    repeat (4) @(negedge mclk);
    // Smallest and largest legal counts first, then random ones.
    for (int i = 0; i < 4; i++) begin
      d = (i == 0) ? 15'h0002 : (i == 1) ? 15'h7fff : 15'($urandom_range(32767, 2));
      b = (i == 0) ? 13'h0003 : (i == 1) ? 13'h1fff : 13'($urandom_range(8191, 3));
      a = (b < 13'h0010) ? 5'(b) : 5'h10;
      a = (i == 0) ? 5'h00 : (i == 1) ? 5'h1f : 5'($urandom_range(32'(a), 0));
      p = (i == 1) | 1'($urandom);
      send(rw(2'h0, 1'b0, 1'b0, !p, d));
      send(fw(1'b0, p, b, a));
      send({20'($urandom), 2'h3});
      check(reference_divide_word, d);
      check(detector_polarity, !p);
      check(main_feedback_count, b);
      check(swallow_count, a);
      check(prescaler_select, p);
    end
    for (int i = 0; i < 5; i++) begin
      bo = (i == 4) | 1'($urandom);
      t = (i < 4) ? i : $urandom_range(8, 4);
      send(rw(2'h0, 1'b0, bo, 1'b0, 15'h0002));
      send(tw(1'b0, 12'(t)));
      chk_sw(t, bo);
    end
    tick(t - 1);
    chk_sw(t, bo);
    tick(1);
    chk_sw(0, 1'b0);
    for (int i = 0; i < 8; i++) begin
      {analog_lock, digital_lock, reference_div_out, feedback_div_out} = 4'($urandom);
      send(rw(2'(i), 1'b0, 1'b0, 1'b0, 15'h0002));
      send(tw(i > 3, 12'h000));
      e = mon_exp(3'(i));
      if (i != 3) check(monitor_output_oe, e[1]);
      if (e[1]) check(monitor_output, e[0]);
      check(dividers_reset, i == 3);
      check(pump_output_oe, i != 3);
    end
    send(tw(1'b0, 12'h000));
    send(rw(2'h0, 1'b0, 1'b0, 1'b0, 15'h0002));
    check(pump_output_oe, 1'b1);
    pump_pulse_active = 1'b1;
    send(fw(1'b1, 1'b0, 13'h0003, 5'h00));
    check(powered_down, 1'b0);
    pump_pulse_active = 1'b0;
    repeat (4) @(negedge mclk);
    check(powered_down, 1'b1);
    check(dividers_reset, 1'b1);
    send(rw(2'h0, 1'b0, 1'b0, 1'b1, 15'h1234));
    check(reference_divide_word, 15'h1234);
    send(fw(1'b0, 1'b0, 13'h0003, 5'h00));
    check(powered_down, 1'b0);
    send(rw(2'h0, 1'b1, 1'b0, 1'b0, 15'h0002));
    check(pump_output_oe, 1'b0);
    pump_pulse_active = 1'b1;
    send(fw(1'b1, 1'b0, 13'h0003, 5'h00));
    check(powered_down, 1'b1);
    end_sim();
  end
endmodule
